// ===== rtl/mirb_defines.svh
`ifndef MIRB_DEFINES_SVH
`define MIRB_DEFINES_SVH
// primary register word offsets (the addr port carries the index itself)
`define MIRB_OFF_MODEM_CTL 4'h0
`define MIRB_OFF_LINE_MODEM 4'h1
`define MIRB_OFF_SELECT 4'h2
`define MIRB_OFF_ACCESS 4'h3
`define MIRB_OFF_SYS_CTL 4'h4
`define MIRB_OFF_LINE_CTL 4'h5
`define MIRB_OFF_RX_INT 4'h6
`define MIRB_OFF_TX_SILO 4'h7
`define MIRB_OFF_MAINT 4'h8
`define MIRB_OFF_RESERVED 4'h9
`define MIRB_OFF_INT_STATUS 4'ha
`define MIRB_OFF_INT_CLEAR 4'hb
`define MIRB_OFF_INT_ENABLE 4'hc
// select register fields
`define MIRB_SEL_SEC_LSB 0
`define MIRB_SEL_LINE_LSB 8
// line control fields: bits 9..14 are per line
`define MIRB_LC_LINE_LSB 9
`define MIRB_LC_SYNC_SEL_BIT 9
`define MIRB_LC_DOUBLE_SYNC_BIT 10
`define MIRB_LC_EXT_ADDR_LSB 4
// system control fields
`define MIRB_SC_EXT_ADDR_LSB 4
`define MIRB_SC_RESTART_BIT 15
// modem control fields
`define MIRB_MC_MODEM_INT_EN_BIT 6
`define MIRB_MC_MODEM_REQ_BIT 7
// interrupt status bits
`define MIRB_INT_RX 0
`define MIRB_INT_TX 1
`define MIRB_INT_MODEM 2
`define MIRB_INT_SYNC 3
// secondary register numbers
`define MIRB_SEC_TX_ADDR 4'h0
`define MIRB_SEC_TX_COUNT 4'h1
`endif

// ===== rtl/mirb_pkg.sv
package mirb_pkg;
   typedef enum logic [1:0] {
      MIRB_HUNT,
      MIRB_ONE_SEEN,
      MIRB_LOCKED
   } mirb_sync_t;
endpackage

// ===== rtl/mirb_bank.sv
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "mirb_defines.svh"
// How it works
// RULE_01: primary registers read and written directly
// RULE_02: select register steers secondary accesses
// RULE_03: exactly ten primary registers decoded; the code decodes offsets 0 to 0xc, thirteen places
// RULE_04: sixteen secondaries per line, sixteen lines
// RULE_05: secondaries in one separate indexed memory
// RULE_06: selection holds register and line numbers
// RULE_07: access register reads/writes selected secondary
// RULE_08: modem control/status with interrupt enable, request
// RULE_09: line status drives and reads modem lines
// RULE_10: system control with restart, extended address
// RULE_11: line control: receiver, sync, format, baud
// RULE_12: receive code stored with its character
// RULE_13: transmit codes stored in readable silo
// RULE_14: per-line transmit address and byte count
// RULE_15: sync on one or two characters
// RULE_16: two preset sync codes per group
// RULE_17: selection persists until next select write
// RULE_18: reserved register inert, reads zero
module mirb_bank #(
   parameter int LINES = 16,
   parameter int SECS = 16,
   parameter int DW = 16,
   parameter int GROUPS = 4,
   // code A of group n in byte n of the low word, code B in byte n of the high word
   parameter logic [63:0] SYNC_CODES = 64'h3232_3232_9696_9696
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [5:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DW-1:0] rdata,
   input wire logic [LINES-1:0] modem_status_in,
   output logic [LINES-1:0] modem_ctl_out,
   input wire logic rx_event,
   input wire logic [3:0] rx_line,
   input wire logic [7:0] rx_char,
   input wire logic [7:0] rx_code,
   input wire logic tx_event,
   input wire logic [7:0] tx_code,
   output logic [LINES-1:0] sync_locked,
   output logic irq
);
   // ****************************************
   // parameter checks
   // ****************************************
   initial begin
      if (LINES != 16 || SECS != 16 || DW != 16 || GROUPS * 4 != LINES) begin
         $error("mirb_bank: unsupported geometry");
      end
   end

   localparam int AW = $clog2(LINES * SECS);
   localparam int SD = 4;

   // ****************************************
   // state
   // ****************************************
   // everything lives in one packed record so that one combinational
   // process computes the whole next state and one clocked process
   // registers it; the cost is a wide vector, the gain is that no field
   // can ever be forgotten in a reset or hold path.
   // field roles:
   //   rdata        read data, valid only in the cycle after a read
   //   modem_ctl    modem scan, init, interrupt enable and request flag
   //   modem_out    per-line modem control outputs
   //   modem_prev   last cycle's modem inputs, for change detection
   //   select       secondary register number and line number
   //   sys_ctl      system control, restart strobe never stored
   //   line_ctl_com line control bits shared by all lines
   //   line_bits    six per-line line control bits, bits 9..14
   //   rx_int       receive interrupt code beside its character
   //   silo         transmit interrupt codes, oldest in the low byte
   //   silo_cnt     number of codes waiting in the silo
   //   maint        maintenance word, stored and read back only
   //   int_status   sticky event bits
   //   int_enable   interrupt enables, same layout as the status
   //   ram          all secondary registers, line-major
   //   sync_st      per-line sync hunt state
   //   locked       per-line sync achieved
   //   irq          registered interrupt level
   typedef struct packed {
      logic [DW-1:0] rdata;
      logic [DW-1:0] modem_ctl;
      logic [LINES-1:0] modem_out;
      logic [LINES-1:0] modem_prev;
      logic [DW-1:0] select;
      logic [DW-1:0] sys_ctl;
      logic [DW-1:0] line_ctl_com;
      logic [LINES*6-1:0] line_bits;
      logic [DW-1:0] rx_int;
      logic [SD*8-1:0] silo;
      logic [2:0] silo_cnt;
      logic [DW-1:0] maint;
      logic [3:0] int_status;
      logic [3:0] int_enable;
      logic [LINES*DW*SECS-1:0] ram;
      logic [LINES*2-1:0] sync_st;
      logic [LINES-1:0] locked;
      logic irq;
   } mirb_state_t;

   mirb_state_t state_reg;
   mirb_state_t state_next;

   // current selection, held until rewritten
   logic [3:0] sel_sec;
   logic [3:0] sel_line;
   logic [AW-1:0] ram_idx;
   assign sel_sec = state_reg.select[`MIRB_SEL_SEC_LSB +: 4]; // RULE_06 RULE_17
   assign sel_line = state_reg.select[`MIRB_SEL_LINE_LSB +: 4]; // RULE_06
   assign ram_idx = {sel_line, sel_sec}; // RULE_02 RULE_05

   // per-line sync hunting, one copy per line
   logic [LINES*2-1:0] sync_nx;
   logic [LINES-1:0] lock_nx;
   genvar g;
   generate
      for (g = 0; g < LINES; g++) begin : g_sync
         logic [7:0] code;
         logic hit;
         logic dbl;
         mirb_pkg::mirb_sync_t st;
         // the per-line sync select picks code A or B of its four-line group
         assign code = state_reg.line_bits[g*6 + 0] ?
            SYNC_CODES[(g/4)*8 +: 8] : SYNC_CODES[32 + (g/4)*8 +: 8]; // RULE_16
         assign dbl = state_reg.line_bits[g*6 + 1];
         assign hit = rx_event && (rx_line == 4'(g)) && (rx_char == code);
         assign st = mirb_pkg::mirb_sync_t'(state_reg.sync_st[g*2 +: 2]);
         always_comb begin
            sync_nx[g*2 +: 2] = state_reg.sync_st[g*2 +: 2];
            lock_nx[g] = state_reg.locked[g];
            if (rx_event && rx_line == 4'(g)) begin
               case (st)
                  mirb_pkg::MIRB_HUNT: begin
                     if (hit && !dbl) begin // RULE_15
                        sync_nx[g*2 +: 2] = 2'(mirb_pkg::MIRB_LOCKED);
                        lock_nx[g] = 1'b1;
                     end else if (hit) begin
                        sync_nx[g*2 +: 2] = 2'(mirb_pkg::MIRB_ONE_SEEN);
                     end
                  end
                  mirb_pkg::MIRB_ONE_SEEN: begin
                     // second sync must follow directly, else start over
                     if (hit) begin // RULE_15
                        sync_nx[g*2 +: 2] = 2'(mirb_pkg::MIRB_LOCKED);
                        lock_nx[g] = 1'b1;
                     end else begin
                        sync_nx[g*2 +: 2] = 2'(mirb_pkg::MIRB_HUNT);
                     end
                  end
                  mirb_pkg::MIRB_LOCKED: begin
                  end
                  default: begin
                     sync_nx[g*2 +: 2] = 2'(mirb_pkg::MIRB_HUNT);
                  end
               endcase
            end
         end
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [3:0] off;
      logic [3:0] ev;
      logic [LINES-1:0] chg;
      logic [2:0] cnt;
      off = addr[3:0];
      ev = 4'h0;
      chg = 16'h0000;
      cnt = 3'h0;
      state_next = state_reg;
      state_next.rdata = '0;
      state_next.sync_st = sync_nx;
      state_next.locked = lock_nx;
      state_next.modem_prev = modem_status_in;
      // a line that newly achieves sync raises the sync event
      if ((lock_nx & ~state_reg.locked) != 16'h0000) begin
         ev[`MIRB_INT_SYNC] = 1'b1;
      end
      // reads: data stands in the following cycle only
      if (rd && addr[5:4] == 2'h0) begin // RULE_01 RULE_03
         case (off)
            `MIRB_OFF_MODEM_CTL: state_next.rdata = state_reg.modem_ctl; // RULE_08
            `MIRB_OFF_LINE_MODEM: state_next.rdata = modem_status_in; // RULE_09
            `MIRB_OFF_SELECT: state_next.rdata = state_reg.select;
            `MIRB_OFF_ACCESS: state_next.rdata = state_reg.ram[ram_idx*DW +: DW]; // RULE_07
            `MIRB_OFF_SYS_CTL: state_next.rdata = state_reg.sys_ctl; // RULE_10
            `MIRB_OFF_LINE_CTL: begin // RULE_11 RULE_06
               state_next.rdata = state_reg.line_ctl_com;
               state_next.rdata[`MIRB_LC_LINE_LSB +: 6] = state_reg.line_bits[sel_line*6 +: 6];
               state_next.rdata[`MIRB_LC_EXT_ADDR_LSB +: 2] =
                  state_reg.sys_ctl[`MIRB_SC_EXT_ADDR_LSB +: 2];
            end
            `MIRB_OFF_RX_INT: state_next.rdata = state_reg.rx_int; // RULE_12
            `MIRB_OFF_TX_SILO: begin // RULE_13
               // reading pops the oldest code; empty silo reads zero
               if (state_reg.silo_cnt != 3'h0) begin
                  state_next.rdata = {8'h80, state_reg.silo[7:0]};
                  state_next.silo = {8'h00, state_reg.silo[SD*8-1:8]};
                  cnt = state_reg.silo_cnt - 3'h1;
                  state_next.silo_cnt = cnt;
               end
            end
            `MIRB_OFF_MAINT: state_next.rdata = state_reg.maint;
            `MIRB_OFF_INT_STATUS: state_next.rdata = {12'h000, state_reg.int_status};
            `MIRB_OFF_INT_ENABLE: state_next.rdata = {12'h000, state_reg.int_enable};
            default: state_next.rdata = '0; // RULE_18
         endcase
      end
      // writes
      if (wr && addr[5:4] == 2'h0) begin // RULE_01
         case (off)
            `MIRB_OFF_MODEM_CTL: begin // RULE_08
               state_next.modem_ctl = wdata;
               if (wdata[1]) begin
                  state_next.modem_out = '0;
                  state_next.modem_ctl = '0;
               end
            end
            `MIRB_OFF_LINE_MODEM: begin // RULE_09
               state_next.modem_out[sel_line] = wdata[0];
            end
            `MIRB_OFF_SELECT: state_next.select = wdata; // RULE_02 RULE_17
            `MIRB_OFF_ACCESS: state_next.ram[ram_idx*DW +: DW] = wdata; // RULE_07 RULE_14
            `MIRB_OFF_SYS_CTL: begin // RULE_10
               state_next.sys_ctl = wdata;
               // restart is a strobe, it never stays set
               state_next.sys_ctl[`MIRB_SC_RESTART_BIT] = 1'b0;
               if (wdata[`MIRB_SC_RESTART_BIT]) begin
                  state_next.silo_cnt = 3'h0;
               end
            end
            `MIRB_OFF_LINE_CTL: begin // RULE_11 RULE_06
               state_next.line_ctl_com = wdata & 16'h01cf;
               state_next.line_bits[sel_line*6 +: 6] = wdata[`MIRB_LC_LINE_LSB +: 6];
               state_next.sync_st[sel_line*2 +: 2] = 2'(mirb_pkg::MIRB_HUNT);
               state_next.locked[sel_line] = 1'b0;
            end
            `MIRB_OFF_MAINT: state_next.maint = wdata;
            `MIRB_OFF_INT_CLEAR: state_next.int_status = state_reg.int_status & ~wdata[3:0];
            `MIRB_OFF_INT_ENABLE: state_next.int_enable = wdata[3:0];
            default: begin // RULE_18
            end
         endcase
      end
      // modem change detection only while scanning is enabled; it sits
      // after the register writes so that a change in the same cycle as
      // a write to the modem control word still leaves its request set
      chg = modem_status_in ^ state_reg.modem_prev;
      if (state_reg.modem_ctl[0] && chg != 16'h0000) begin // RULE_08
         state_next.modem_ctl[`MIRB_MC_MODEM_REQ_BIT] = 1'b1;
         if (state_reg.modem_ctl[`MIRB_MC_MODEM_INT_EN_BIT]) begin
            ev[`MIRB_INT_MODEM] = 1'b1;
         end
      end
      // receive and transmit events after clears, so a set wins
      if (rx_event) begin // RULE_12
         state_next.rx_int = {rx_code, rx_char};
         ev[`MIRB_INT_RX] = 1'b1;
      end
      if (tx_event) begin // RULE_13
         // a full silo drops the newest code rather than overwrite
         cnt = state_next.silo_cnt;
         if (cnt != 3'(SD)) begin
            state_next.silo[cnt[1:0]*8 +: 8] = tx_code;
            state_next.silo_cnt = cnt + 3'h1;
         end
         ev[`MIRB_INT_TX] = 1'b1;
      end
      state_next.int_status = state_next.int_status | ev;
      state_next.irq = (state_next.int_status & state_next.int_enable) != 4'h0;
      if (srst) begin
         state_next = '0;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   assign rdata = state_reg.rdata;
   assign modem_ctl_out = state_reg.modem_out;
   assign sync_locked = state_reg.locked;
   assign irq = state_reg.irq;
endmodule

// ===== tb/mirb_bank_monitor.sv
`timescale 1ns/10ps
// ****
// register port checks
// ****
module mirb_bank_monitor #(
   parameter int LINES = 16,
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [5:0] addr,
   input wire logic [DW-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DW-1:0] rdata,
   input wire logic [LINES-1:0] modem_ctl_out,
   input wire logic irq
);
   logic [DW-1:0] mem_reg [256];
   logic [255:0] vld_reg;
   logic [7:0] sel_reg;
   logic [1:0] ext_reg;
   logic [DW-1:0] en_reg, en_old_reg, acc_exp;
   assign acc_exp = mem_reg[sel_reg];
   // shadows of host writes; ram resets to zero, but only written entries are judged
   always_ff @(posedge clk) begin
      en_old_reg <= en_reg;
      if (srst) {vld_reg, sel_reg, ext_reg, en_reg} <= '0;
      else if (wr && addr == 6'h02) sel_reg <= {wdata[11:8], wdata[3:0]};
      else if (wr && addr == 6'h03) {vld_reg[sel_reg], mem_reg[sel_reg]} <= {1'b1, wdata};
      else if (wr && addr == 6'h04) ext_reg <= wdata[5:4];
      else if (wr && addr == 6'h0c) en_reg <= wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   chk_rdata_quiet: assert property (!$past(rd) |-> rdata == '0)
      else $error("rdata not zero without read");
   chk_reserved_zero: assert property (rd && addr == 6'h09 |=> rdata == '0)
      else $error("reserved read not zero");
   chk_unmapped_zero: assert property (rd && addr > 6'h0c |=> rdata == '0)
      else $error("unmapped read not zero");
   chk_access_data: assert property (rd && addr == 6'h03 && vld_reg[sel_reg]
      |=> rdata == $past(acc_exp)) else $error("access read wrong");
   chk_irq_enabled: assert property (irq |-> (en_reg | en_old_reg) != '0)
      else $error("irq with nothing enabled");
   chk_modem_hold: assert property (!$past(srst) && !$past(wr) && !$past(wr, 2)
      |-> $stable(modem_ctl_out)) else $error("modem outputs moved unasked");
   chk_silo_marked: assert property (rd && addr == 6'h07
      |=> rdata[15:8] == 8'h80 || rdata == '0) else $error("silo word malformed");
   chk_ext_readback: assert property (rd && addr == 6'h05
      |=> rdata[5:4] == $past(ext_reg)) else $error("ext address readback wrong");
   cov_access_read: cover property (rd && addr == 6'h03 && vld_reg[sel_reg]);
   cov_irq_up: cover property ($rose(irq));
   cov_write_read: cover property (wr ##2 rd);
endmodule

// ===== tb/mirb_host.sv
`timescale 1ns/10ps
// ****
// host model on the register port
// ****
module mirb_host (
   input wire logic clk,
   input wire logic [15:0] rdata,
   output logic [5:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   initial {addr, wdata, wr, rd} = '0;
   // write, then an idle edge so no strobe is set twice in one step
   task automatic put(input logic [5:0] a, input logic [15:0] d);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk);
      {wdata, wr} <= {~d, 1'b0};
      @(posedge clk);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic get(input logic [5:0] a, output logic [15:0] d);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
endmodule

// ===== tb/mirb_bank_tb.sv
`timescale 1ns/10ps
// ****
// bench top and reference model
// ****
module mirb_bank_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr, rd, rx_ev, tx_ev, irq;
   logic [5:0] addr;
   logic [3:0] rx_ln;
   logic [7:0] rx_ch, rx_cd, tx_cd;
   logic [15:0] wdata, rdata, mst, mco, slk, d;
   logic [15:0] ram_m [256];
   logic [7:0] sel_m [8];
   logic [7:0] silo_m [$];
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 32'hf8685881;
   int i;
   always #10 clk = ~clk;
   mirb_bank mirb_bank_inst (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .modem_status_in(mst), .modem_ctl_out(mco), .rx_event(rx_ev),
      .rx_line(rx_ln), .rx_char(rx_ch), .rx_code(rx_cd), .tx_event(tx_ev), .tx_code(tx_cd),
      .sync_locked(slk), .irq(irq));
   mirb_host mirb_host_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd));
   task automatic close_out();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
      checks++;
      if (act !== exp) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, exp, act);
      end
   endtask
   task automatic w(input logic [5:0] a, input logic [15:0] v);
      mirb_host_inst.put(a, v);
   endtask
   task automatic rc(input string nm, input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] v;
      mirb_host_inst.get(a, v);
      chk(nm, exp, v);
   endtask
   // one transmit code; the model silo is four deep and drops when full
   task automatic tx_push(input logic [7:0] c);
      {tx_cd, tx_ev} <= {c, 1'b1};
      @(posedge clk);
      tx_ev <= 1'b0;
      @(posedge clk);
      if (silo_m.size() < 4) silo_m.push_back(c);
   endtask
   // one received character on one line
   task automatic rx_push(input logic [3:0] ln, input logic [7:0] c);
      {rx_ln, rx_ch, rx_cd, rx_ev} <= {ln, c, 8'h00, 1'b1};
      @(posedge clk);
      rx_ev <= 1'b0;
      @(posedge clk);
   endtask
   // hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      {rx_ev, tx_ev, rx_ln, rx_ch, rx_cd, tx_cd} = '0;
      mst <= $random(seed);
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      // after reset only the modem status index shows live inputs
      for (i = 0; i < 16; i++) rc("prim", i[5:0], (i == 1) ? mst : 16'h0000);
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         w(6'h02, d & 16'h0f0f);
         sel_m[i] = {d[11:8], d[3:0]};
         d = $random(seed);
         w(6'h03, d);
         ram_m[sel_m[i]] = d;
      end
      // inert places must not disturb the selection
      w(6'h09, 16'hffff);
      w(6'h0d, 16'hffff);
      rc("resv", 6'h09, 16'h0000);
      rc("acc", 6'h03, ram_m[sel_m[7]]);
      for (i = 0; i < 8; i++) begin
         w(6'h02, {4'h0, sel_m[i][7:4], 4'h0, sel_m[i][3:0]});
         rc("acc", 6'h03, ram_m[sel_m[i]]);
         rc("acc", 6'h03, ram_m[sel_m[i]]);
      end
      d = $random(seed);
      w(6'h02, 16'h0300);
      w(6'h05, d);
      rc("lctl", 6'h05, d & 16'h7fcf);
      w(6'h02, 16'h0c00);
      rc("lctl", 6'h05, d & 16'h01cf);
      w(6'h04, 16'h0020);
      rc("lctl", 6'h05, (d & 16'h01cf) | 16'h0020);
      w(6'h01, 16'h0001);
      chk("mco", 16'h1000, mco);
      w(6'h0c, 16'h0003);
      d = $random(seed);
      {rx_ln, rx_ch, rx_cd, rx_ev} <= {d[7:4], 4'h4, d[3:0], d[15:8], 1'b1};
      @(posedge clk);
      rx_ev <= 1'b0;
      repeat (3) @(posedge clk);
      chk("irq", 16'h0001, {15'h0, irq});
      rc("ric", 6'h06, {d[15:8], 4'h4, d[3:0]});
      rc("ists", 6'h0a, 16'h0001);
      w(6'h0b, 16'h0001);
      repeat (2) @(posedge clk);
      chk("irq", 16'h0000, {15'h0, irq});
      for (i = 0; i < 5; i++) begin
         d = $random(seed);
         tx_push(d[7:0]);
      end
      rc("ists", 6'h0a, 16'h0002);
      for (i = 0; i < 5; i++) begin
         d = silo_m.size() ? {8'h80, silo_m.pop_front()} : 16'h0000;
         rc("silo", 6'h07, d);
      end
      tx_push(8'h11);
      w(6'h04, 16'h8000);
      silo_m.delete();
      rc("silo", 6'h07, 16'h0000);
      // line 5 (group 1) hunts for two code A characters in a row
      w(6'h02, 16'h0500);
      w(6'h05, 16'h0600);
      rx_push(4'h5, 8'h96);
      chk("slk", 16'h0000, slk);
      rx_push(4'h5, 8'h96);
      chk("slk", 16'h0020, slk);
      // line 6 locks on a single code B character
      w(6'h02, 16'h0600);
      w(6'h05, 16'h0000);
      rx_push(4'h6, 8'h32);
      chk("slk", 16'h0060, slk);
      // a modem input change while scanning sets the request flag
      w(6'h00, 16'h0041);
      mst <= mst ^ 16'h0001;
      repeat (2) @(posedge clk);
      rc("mctl", 6'h00, 16'h00c1);
      rc("ists", 6'h0a, 16'h000f);
      w(6'h0c, 16'h0000);
      repeat (3) @(posedge clk);
      chk("irq", 16'h0000, {15'h0, irq});
      close_out();
   end
endmodule
bind mirb_bank mirb_bank_monitor #(.LINES(LINES), .DW(DW)) mirb_bank_monitor_inst (.clk(clk),
   .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .modem_ctl_out(modem_ctl_out), .irq(irq));
